// *** logic/dwp_defines.svh ***
`ifndef DWP_DEFINES_SVH
`define DWP_DEFINES_SVH

// address byte fields
`define DWP_PRESET        6'h26
`define DWP_BCAST         8'h90
`define DWP_RW_WRITE      1'h0
`define DWP_BITS_PER_BYTE 4'h8

// power-down field encodings
`define DWP_PD_NORMAL     2'h0
`define DWP_PD_1K         2'h1
`define DWP_PD_100K       2'h2
`define DWP_PD_HIZ        2'h3

// converter code range and reset value
`define DWP_CODE_RESET    12'h000
`define DWP_CODE_MAX      12'hFFF

// link rates in kbit/s and system clock in kHz
`define DWP_MCLK_KHZ      25000
`define DWP_STD_KBPS      100
`define DWP_FAST_KBPS     400
`define DWP_HS_KBPS       3400

// quarter bit time in mclk cycles, rounded up
`define DWP_QTR_STD  ((`DWP_MCLK_KHZ + 4 * `DWP_STD_KBPS - 1) / (4 * `DWP_STD_KBPS))
`define DWP_QTR_FAST ((`DWP_MCLK_KHZ + 4 * `DWP_FAST_KBPS - 1) / (4 * `DWP_FAST_KBPS))
`define DWP_QTR_HS   ((`DWP_MCLK_KHZ + 4 * `DWP_HS_KBPS - 1) / (4 * `DWP_HS_KBPS))

// link cycles after reset release before the select pin is caught
`define DWP_SEL_WAIT      2'h3

`endif

// *** logic/dwp_device.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dwp_defines.svh"

module dwp_device (
    input  wire logic        link_clk,
    input  wire logic        mclk,
    input  wire logic        rst_b,
    dwp_if.device            bus,
    input  wire logic        addr_select_pin,
    output logic [11:0]      converter_code_bits,
    output logic             powerdown_mode_hi,
    output logic             powerdown_mode_lo,
    output logic             powerdown_active,
    output logic             update_pulse
);

    // link side
    dwp_pkg::dwp_dev_state_t state_r;
    logic        scl_m_r;
    logic        scl_s_r;
    logic        scl_q_r;
    logic        sda_m_r;
    logic        sda_s_r;
    logic        sda_q_r;
    logic        sel_m_r;
    logic        sel_s_r;
    logic [1:0]  sel_cnt_r;
    logic        sel_done_r;
    logic        sel_bit_r;
    logic [3:0]  bit_cnt_r;
    logic [7:0]  shift_r;
    logic [5:0]  hi_r;
    logic [13:0] word_r;
    logic        lsb_phase_r;
    logic        tgl_r;
    logic        sda_oe_r;
    logic        start_det;
    logic        stop_det;
    logic        scl_rise;
    logic        scl_fall;
    logic        byte_end;

    // system side
    logic        tgl_m_r;
    logic        tgl_s_r;
    logic        tgl_q_r;
    logic [11:0] code_r;
    logic [1:0]  pd_r;
    logic        pd_act_r;
    logic        upd_r;

    // address byte decode: preset, select bit and write direction, or broadcast
    function automatic logic addr_ok(input logic [7:0] b, input logic sel);
        // nothing else, so no general call or ten-bit prefix
        addr_ok = (b == {`DWP_PRESET, sel, `DWP_RW_WRITE}) || (b == `DWP_BCAST);
    endfunction

    // any nonzero field powers the output stage down
    function automatic logic pd_off(input logic [1:0] pd);
        pd_off = (pd != `DWP_PD_NORMAL);
    endfunction

    // only the data line is ever driven, and only low
    assign bus.sda_oe_s = sda_oe_r;

    // line synchronisers plus one history stage for edge detection
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_q_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_m_r <= bus.scl;
            scl_s_r <= scl_m_r;
            scl_q_r <= scl_s_r;
            sda_m_r <= bus.sda;
            sda_s_r <= sda_m_r;
            sda_q_r <= sda_s_r;
        end
    end

    // start is data falling with clock held high
    assign start_det = scl_s_r & scl_q_r & sda_q_r & ~sda_s_r;
    // stop is data rising with clock held high
    assign stop_det  = scl_s_r & scl_q_r & ~sda_q_r & sda_s_r;
    // data is taken only on clock edges
    assign scl_rise  = scl_s_r & ~scl_q_r;
    assign scl_fall  = ~scl_s_r & scl_q_r;
    assign byte_end  = scl_fall && (bit_cnt_r == `DWP_BITS_PER_BYTE);

    // catch the select pin once, shortly after reset release
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_m_r    <= 1'b0;
            sel_s_r    <= 1'b0;
            sel_cnt_r  <= 2'h0;
            sel_done_r <= 1'b0;
            sel_bit_r  <= 1'b0;
        end else begin
            sel_m_r <= addr_select_pin;
            sel_s_r <= sel_m_r;
            if (!sel_done_r) begin
                if (sel_cnt_r == `DWP_SEL_WAIT) begin
                    sel_bit_r  <= sel_s_r;
                    sel_done_r <= 1'b1;
                end else begin
                    sel_cnt_r <= sel_cnt_r + 2'h1;
                end
            end
        end
    end

    // receive state machine; start and stop override every state
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r     <= dwp_pkg::DWP_D_IDLE;
            bit_cnt_r   <= 4'h0;
            shift_r     <= 8'h00;
            lsb_phase_r <= 1'b0;
            sda_oe_r    <= 1'b0;
        end else if (start_det) begin
            // repeated start drops a half pair
            state_r     <= dwp_pkg::DWP_D_ADDR;
            bit_cnt_r   <= 4'h0;
            lsb_phase_r <= 1'b0;
            sda_oe_r    <= 1'b0;
        end else if (stop_det) begin
            state_r     <= dwp_pkg::DWP_D_IDLE;
            lsb_phase_r <= 1'b0;
            sda_oe_r    <= 1'b0;
        end else begin
            unique case (state_r)
                dwp_pkg::DWP_D_IDLE, dwp_pkg::DWP_D_IGNORE: begin
                    sda_oe_r <= 1'b0;
                end
                dwp_pkg::DWP_D_ADDR, dwp_pkg::DWP_D_DATA: begin
                    if (scl_rise && bit_cnt_r != `DWP_BITS_PER_BYTE) begin
                        shift_r   <= {shift_r[6:0], sda_s_r};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (byte_end) begin
                        if (state_r == dwp_pkg::DWP_D_DATA) begin
                            sda_oe_r <= 1'b1;
                            state_r  <= dwp_pkg::DWP_D_DATA_ACK;
                        end else if (addr_ok(shift_r, sel_bit_r)) begin
                            // pull data low for ninth clock
                            sda_oe_r <= 1'b1;
                            state_r  <= dwp_pkg::DWP_D_ADDR_ACK;
                        end else begin
                            state_r <= dwp_pkg::DWP_D_IGNORE;
                        end
                    end
                end
                dwp_pkg::DWP_D_ADDR_ACK, dwp_pkg::DWP_D_DATA_ACK: begin
                    if (scl_fall) begin
                        sda_oe_r  <= 1'b0;
                        bit_cnt_r <= 4'h0;
                        state_r   <= dwp_pkg::DWP_D_DATA;
                        if (state_r == dwp_pkg::DWP_D_DATA_ACK) begin
                            lsb_phase_r <= ~lsb_phase_r;
                        end
                    end
                end
                default: begin
                    state_r  <= dwp_pkg::DWP_D_IDLE;
                    sda_oe_r <= 1'b0;
                end
            endcase
        end
    end

    // byte assembly: control byte held, low byte completes the word
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            hi_r   <= 6'h00;
            word_r <= 14'h0000;
        end else if (!start_det && !stop_det && byte_end
                     && state_r == dwp_pkg::DWP_D_DATA) begin
            // top two control bits are don't care
            if (!lsb_phase_r) begin
                hi_r <= shift_r[5:0];
            end else begin
                word_r <= {hi_r, shift_r};
            end
        end
    end

    // commit toggle at the fall that ends the low-byte acknowledge
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            tgl_r <= 1'b0;
        end else if (!start_det && !stop_det && scl_fall && lsb_phase_r
                     && state_r == dwp_pkg::DWP_D_DATA_ACK) begin
            tgl_r <= ~tgl_r;
        end
    end

    // toggle crossing into mclk; word_r is stable long before and after
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tgl_m_r <= 1'b0;
            tgl_s_r <= 1'b0;
            tgl_q_r <= 1'b0;
        end else begin
            tgl_m_r <= tgl_r;
            tgl_s_r <= tgl_m_r;
            tgl_q_r <= tgl_s_r;
        end
    end

    // converter register, loaded only by a completed pair
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            code_r   <= `DWP_CODE_RESET;
            pd_r     <= `DWP_PD_NORMAL;
            pd_act_r <= 1'b0;
            upd_r    <= 1'b0;
        end else begin
            upd_r <= 1'b0;
            if (tgl_s_r != tgl_q_r) begin
                code_r   <= word_r[11:0];
                pd_r     <= word_r[13:12];
                pd_act_r <= pd_off(word_r[13:12]);
                upd_r    <= 1'b1;
            end
        end
    end

    assign converter_code_bits = code_r;
    assign powerdown_mode_hi   = pd_r[1];
    assign powerdown_mode_lo   = pd_r[0];
    assign powerdown_active    = pd_act_r;
    assign update_pulse        = upd_r;

endmodule // dwp_device

`default_nettype wire

// *** logic/dwp_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// two-wire bus with pull-ups: a line is low while any party enables its driver
interface dwp_if;
    logic scl_oe_m;
    logic sda_oe_m;
    logic sda_oe_s;
    logic scl;
    logic sda;

    // wired-and resolution of the open-drain lines
    assign scl = ~scl_oe_m;
    assign sda = ~(sda_oe_m | sda_oe_s);

    modport device (
        input  scl,
        input  sda,
        output sda_oe_s
    );

    modport master (
        input  scl,
        input  sda,
        output scl_oe_m,
        output sda_oe_m
    );
endinterface

`default_nettype wire

// *** logic/dwp_master.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dwp_defines.svh"

module dwp_master #(
    parameter int QTR_CYC = `DWP_QTR_STD
) (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    dwp_if.master            bus,
    input  wire logic        wr_req,
    input  wire logic [6:0]  wr_addr,
    input  wire logic [1:0]  wr_pd,
    input  wire logic [11:0] wr_code,
    output logic             busy,
    output logic             done,
    output logic             nack
);

    dwp_pkg::dwp_mst_state_t state_r;
    logic [15:0] qcnt_r;
    logic [1:0]  phase_r;
    logic [1:0]  byte_r;
    logic [3:0]  bit_r;
    logic [23:0] frame_r;
    logic        scl_oe_r;
    logic        sda_oe_r;
    logic        busy_r;
    logic        done_r;
    logic        nack_r;
    logic        sda_m_r;
    logic        sda_s_r;
    logic        tick;

    assign bus.scl_oe_m = scl_oe_r;
    assign bus.sda_oe_m = sda_oe_r;
    assign busy         = busy_r;
    assign done         = done_r;
    assign nack         = nack_r;
    assign tick         = (qcnt_r == 16'(QTR_CYC - 1));

    // data line synchroniser for the acknowledge sample
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
        end else begin
            sda_m_r <= bus.sda;
            sda_s_r <= sda_m_r;
        end
    end

    // quarter bit divider, runs only during a frame
    // quarter period sets bit rate
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            qcnt_r <= 16'h0000;
        end else if (state_r == dwp_pkg::DWP_M_IDLE || tick) begin
            qcnt_r <= 16'h0000;
        end else begin
            qcnt_r <= qcnt_r + 16'h0001;
        end
    end

    // frame sequencer: start, three bytes of nine clocks or fewer on a nack, stop
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r  <= dwp_pkg::DWP_M_IDLE;
            phase_r  <= 2'h0;
            byte_r   <= 2'h0;
            bit_r    <= 4'h0;
            frame_r  <= 24'h000000;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            busy_r   <= 1'b0;
            done_r   <= 1'b0;
            nack_r   <= 1'b0;
        end else begin
            done_r <= 1'b0;
            unique case (state_r)
                dwp_pkg::DWP_M_IDLE: begin
                    if (wr_req) begin
                        frame_r <= {wr_addr, `DWP_RW_WRITE, 2'h0, wr_pd, wr_code};
                        state_r <= dwp_pkg::DWP_M_START;
                        phase_r <= 2'h0;
                        byte_r  <= 2'h0;
                        bit_r   <= 4'h0;
                        busy_r  <= 1'b1;
                        nack_r  <= 1'b0;
                    end
                end
                dwp_pkg::DWP_M_START: begin
                    if (tick) begin
                        phase_r <= phase_r + 2'h1;
                        if (phase_r == 2'h0) begin
                            sda_oe_r <= 1'b1;
                        end else begin
                            scl_oe_r <= 1'b1;
                            phase_r  <= 2'h0;
                            state_r  <= dwp_pkg::DWP_M_BITS;
                        end
                    end
                end
                dwp_pkg::DWP_M_BITS: begin
                    if (tick) begin
                        phase_r <= phase_r + 2'h1;
                        unique case (phase_r)
                            2'h0: sda_oe_r <= (bit_r == `DWP_BITS_PER_BYTE) ? 1'b0 : ~frame_r[23];
                            2'h1: scl_oe_r <= 1'b0;
                            2'h2: begin
                                if (bit_r == `DWP_BITS_PER_BYTE && sda_s_r) begin
                                    nack_r <= 1'b1;
                                end
                            end
                            2'h3: begin
                                scl_oe_r <= 1'b1;
                                // eight bits msb first, then ack
                                if (bit_r == `DWP_BITS_PER_BYTE) begin
                                    bit_r <= 4'h0;
                                    byte_r <= byte_r + 2'h1;
                                    if (byte_r == 2'h2 || nack_r) begin
                                        state_r <= dwp_pkg::DWP_M_STOP;
                                    end
                                end else begin
                                    bit_r   <= bit_r + 4'h1;
                                    frame_r <= {frame_r[22:0], 1'b0};
                                end
                            end
                        endcase
                    end
                end
                dwp_pkg::DWP_M_STOP: begin
                    if (tick) begin
                        phase_r <= phase_r + 2'h1;
                        unique case (phase_r)
                            2'h0: sda_oe_r <= 1'b1;
                            2'h1: scl_oe_r <= 1'b0;
                            2'h2: sda_oe_r <= 1'b0;
                            2'h3: begin
                                state_r <= dwp_pkg::DWP_M_IDLE;
                                busy_r  <= 1'b0;
                                done_r  <= 1'b1;
                            end
                        endcase
                    end
                end
            endcase
        end
    end

endmodule // dwp_master

`default_nettype wire

// *** logic/dwp_pkg.sv ***
`default_nettype none

package dwp_pkg;

    typedef enum logic [2:0] {
        DWP_D_IDLE,
        DWP_D_ADDR,
        DWP_D_ADDR_ACK,
        DWP_D_DATA,
        DWP_D_DATA_ACK,
        DWP_D_IGNORE
    } dwp_dev_state_t;

    typedef enum logic [1:0] {
        DWP_M_IDLE,
        DWP_M_START,
        DWP_M_BITS,
        DWP_M_STOP
    } dwp_mst_state_t;

endpackage

`default_nettype wire

// *** testbench/dwp_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dwp_defines.svh"

// watches the two-wire link from the link clock side
module dwp_asserts (
    input wire logic link_clk,
    input wire logic rst_b,
    input wire logic scl_oe_m,
    input wire logic sda_oe_m,
    input wire logic sda_oe_s,
    input wire logic scl,
    input wire logic sda,
    input wire logic addr_select_pin
);
    logic       scl_r, sda_r, first_r, ign_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r;
    logic [6:0] oe_cnt_r;
    logic       start_seen, rise_seen, hit;

    // start and clock rise seen on two samples
    assign start_seen = scl && scl_r && sda_r && !sda;
    assign rise_seen  = scl && !scl_r;
    assign hit = (sh_r == {`DWP_PRESET, addr_select_pin, `DWP_RW_WRITE}) || (sh_r == `DWP_BCAST);

    // sampled copies of both lines
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_r <= 1'h1;
            sda_r <= 1'h1;
        end else begin
            scl_r <= scl;
            sda_r <= sda;
        end
    end

    // bit position within the byte and address byte capture
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_r   <= 4'h0;
            first_r <= 1'h0;
            sh_r    <= 8'h00;
        end else if (start_seen) begin
            bit_r   <= 4'h0;
            first_r <= 1'h1;
        end else if (rise_seen) begin
            bit_r <= (bit_r == 4'h9) ? 4'h1 : bit_r + 4'h1;
            if (bit_r < 4'h8)
                sh_r <= {sh_r[6:0], sda};
            if (bit_r == 4'h9)
                first_r <= 1'h0;
        end
    end

    // unselected frame flag, cleared by the next start
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b)
            ign_r <= 1'h0;
        else if (start_seen)
            ign_r <= 1'h0;
        else if (rise_seen && bit_r == 4'h8 && first_r && !hit)
            ign_r <= 1'h1;
    end

    // length of the device's pull on the data line
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b)
            oe_cnt_r <= 7'h00;
        else
            oe_cnt_r <= sda_oe_s ? oe_cnt_r + 7'h01 : 7'h00;
    end

    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!rst_b);

    sequence s_ninth_hi;
        $rose(scl) ##0 sda_oe_s;
    endsequence
    property p_ack_low_clk;
        $changed(sda_oe_s) |-> !scl && !scl_r;
    endproperty
    property p_ack_bit;
        $rose(sda_oe_s) |-> bit_r == 4'h8;
    endproperty
    property p_ack_hold;
        s_ninth_hi |=> sda_oe_s [*8];
    endproperty
    property p_ack_len;
        oe_cnt_r <= 7'h3C;
    endproperty
    property p_addr_ok;
        $rose(sda_oe_s) && first_r |-> hit;
    endproperty
    property p_match_ack;
        rise_seen && bit_r == 4'h8 && first_r && hit |-> sda_oe_s;
    endproperty
    property p_bcast;
        rise_seen && bit_r == 4'h8 && first_r && sh_r == `DWP_BCAST |-> sda_oe_s;
    endproperty
    property p_ignore;
        ign_r |-> !sda_oe_s;
    endproperty
    property p_data_ack;
        rise_seen && bit_r == 4'h8 && !first_r && !ign_r |-> sda_oe_s;
    endproperty
    property p_start_src;
        start_seen |-> sda_oe_m && !sda_oe_s && !scl_oe_m;
    endproperty

    a_ack_low_clk: assert property (p_ack_low_clk) else $error("ack moved while clock high");
    a_ack_bit: assert property (p_ack_bit) else $error("ack not after eighth bit");
    a_ack_hold: assert property (p_ack_hold) else $error("ack dropped in ninth clock");
    a_ack_len: assert property (p_ack_len) else $error("device held data line too long");
    a_addr_ok: assert property (p_addr_ok) else $error("wrong address acknowledged");
    a_match_ack: assert property (p_match_ack) else $error("own address not acknowledged");
    a_bcast: assert property (p_bcast) else $error("broadcast not acknowledged");
    a_ignore: assert property (p_ignore) else $error("unselected device drove line");
    a_data_ack: assert property (p_data_ack) else $error("data byte not acknowledged");
    a_start_src: assert property (p_start_src) else $error("start not made by master");
endmodule // dwp_asserts

`default_nettype wire

// *** testbench/i2c_slave_dac_write_port_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dwp_defines.svh"

module i2c_slave_dac_write_port_test;
    localparam int QTR       = 16;
    localparam int FRAME_CYC = (2 + 108 + 4) * QTR + 1;

    logic        mclk = 1'h0;
    logic        link_clk = 1'h0;
    logic        rst_b, sel_pin, sel_boot, wr_req;
    logic [6:0]  wr_addr, a;
    logic [1:0]  wr_pd, exp_pd;
    logic [11:0] wr_code, converter_code_bits, exp_code;
    logic        powerdown_mode_hi, powerdown_mode_lo, powerdown_active;
    logic        update_pulse, busy, done, nack;
    logic [31:0] seed;
    int          failures, n_checks, cyc;

    dwp_if u_dwp_if ();
    dwp_master #(.QTR_CYC(QTR)) u_dwp_master (.mclk(mclk), .rst_b(rst_b), .bus(u_dwp_if),
        .wr_req(wr_req), .wr_addr(wr_addr), .wr_pd(wr_pd), .wr_code(wr_code),
        .busy(busy), .done(done), .nack(nack));
    dwp_device u_dwp_device (.link_clk(link_clk), .mclk(mclk), .rst_b(rst_b), .bus(u_dwp_if),
        .addr_select_pin(sel_pin), .converter_code_bits(converter_code_bits),
        .powerdown_mode_hi(powerdown_mode_hi), .powerdown_mode_lo(powerdown_mode_lo),
        .powerdown_active(powerdown_active), .update_pulse(update_pulse));
    dwp_asserts u_dwp_asserts (.link_clk(link_clk), .rst_b(rst_b),
        .scl_oe_m(u_dwp_if.scl_oe_m), .sda_oe_m(u_dwp_if.sda_oe_m),
        .sda_oe_s(u_dwp_if.sda_oe_s), .scl(u_dwp_if.scl), .sda(u_dwp_if.sda),
        .addr_select_pin(sel_boot));

    // system clock and unrelated link clock
    initial begin
        forever #20 mclk = ~mclk;
    end
    initial begin
        #7;
        forever #24 link_clk = ~link_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // address accepted with the strap value caught at power-up
    function automatic logic match(input logic [6:0] ad);
        return ad == {`DWP_PRESET, sel_boot} || {ad, `DWP_RW_WRITE} == `DWP_BCAST;
    endfunction

    task automatic cmp_val(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_cnt(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            failures++;
            $display("BAD %0t count %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        if (failures == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // one frame from the master, then outputs against the expected state
    task automatic send(input logic [6:0] ad, input logic [1:0] pd, input logic [11:0] c);
        int   n;
        int   ups;
        logic ok;
        ok = match(ad);
        @(posedge mclk);
        #1;
        wr_req  = 1'h1;
        wr_addr = ad;
        wr_pd   = pd;
        wr_code = c;
        @(posedge mclk);
        #1;
        wr_req = 1'h0;
        n      = 1;
        ups    = 0;
        cmp_val(12'(busy), 12'h001);
        while (done !== 1'h1 && n < 4000) begin
            @(posedge mclk);
            #1;
            n++;
            if (update_pulse === 1'h1)
                ups++;
        end
        if (ok) begin
            cmp_cnt(n, FRAME_CYC);
            exp_code = c;
            exp_pd   = pd;
        end
        cmp_cnt(int'(done === 1'h1), 1);
        cmp_val(12'(busy), 12'h000);
        cmp_val(12'(nack), 12'(!ok));
        cmp_cnt(ups, int'(ok));
        cmp_val(converter_code_bits, exp_code);
        cmp_val(12'({powerdown_mode_hi, powerdown_mode_lo}), 12'(exp_pd));
        cmp_val(12'(powerdown_active), 12'(exp_pd != `DWP_PD_NORMAL));
    endtask

    // cycle watchdog against a hung frame
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            finish_test();
        end
    end

    initial begin
        rst_b    = 1'h0;
        sel_pin  = 1'h0;
        sel_boot = 1'h0;
        wr_req   = 1'h0;
        wr_addr  = 7'h00;
        wr_pd    = 2'h0;
        wr_code  = 12'h000;
        seed     = 32'h3AED7E51;
        exp_code = `DWP_CODE_RESET;
        exp_pd   = `DWP_PD_NORMAL;
        repeat (5) @(posedge mclk);
        #1;
        rst_b = 1'h1;
        repeat (12) @(posedge mclk);
        #1;
        cmp_val(converter_code_bits, `DWP_CODE_RESET);
        cmp_val(12'({powerdown_mode_hi, powerdown_mode_lo}), 12'(`DWP_PD_NORMAL));
        send(7'h4C, `DWP_PD_NORMAL, `DWP_CODE_MAX);
        send(7'h48, `DWP_PD_1K, 12'h000);
        send(7'h4D, `DWP_PD_100K, 12'h5A5);
        send(7'h4C, `DWP_PD_HIZ, 12'h800);
        send(7'h4C, `DWP_PD_100K, 12'h3C3);
        // strap moves after power-up and must be ignored
        sel_pin = 1'h1;
        send(7'h4D, `DWP_PD_1K, 12'h777);
        send(7'h4C, `DWP_PD_NORMAL, 12'h123);
        for (int i = 0; i < 7; i++) begin
            seed = xs(seed);
            a    = seed[1] ? seed[14:8] : {`DWP_PRESET, seed[0]};
            send(a, seed[3:2], seed[27:16]);
        end
        // second power-up with the strap high: outputs clear, select becomes one
        rst_b    = 1'h0;
        sel_boot = sel_pin;
        exp_code = `DWP_CODE_RESET;
        exp_pd   = `DWP_PD_NORMAL;
        repeat (5) @(posedge mclk);
        #1;
        cmp_val(converter_code_bits, `DWP_CODE_RESET);
        rst_b = 1'h1;
        repeat (12) @(posedge mclk);
        #1;
        cmp_val(12'(powerdown_active), 12'h000);
        send(7'h4C, `DWP_PD_1K, 12'h9E1);
        send(7'h4D, `DWP_PD_NORMAL, 12'hABC);
        finish_test();
    end
endmodule // i2c_slave_dac_write_port_test

`default_nettype wire
